// ### include/bfx_map.vh
// Notes on behaviour
// - rotate left through carry, five flags, 1 clock
// - rotate right through carry, five flags, 1 clock
// - bit store copies register bit to T
// - bit load writes T into register bit
// - io bit set forces one bit, 2 clocks
// - io bit clear forces one bit, 2 clocks
// - overflow flag set/clear, 1 clock each
// - half carry set/clear, 1 clock each
// - sign flag set/clear, 1 clock each
`ifndef BFX_MAP_VH
`define BFX_MAP_VH
// status flag bit positions
`define BFX_FLAG_C 3'h0
`define BFX_FLAG_Z 3'h1
`define BFX_FLAG_N 3'h2
`define BFX_FLAG_V 3'h3
`define BFX_FLAG_S 3'h4
`define BFX_FLAG_H 3'h5
`define BFX_FLAG_T 3'h6
`define BFX_FLAG_I 3'h7
// operation codes on the op port
`define BFX_OP_NOP 4'h0
`define BFX_OP_ROTL 4'h1
`define BFX_OP_ROTR 4'h2
`define BFX_OP_BSTORE 4'h3
`define BFX_OP_BLOAD 4'h4
`define BFX_OP_IOSET 4'h5
`define BFX_OP_IOCLR 4'h6
`define BFX_OP_VSET 4'h7
`define BFX_OP_VCLR 4'h8
`define BFX_OP_HSET 4'h9
`define BFX_OP_HCLR 4'hA
`define BFX_OP_SSET 4'hB
`define BFX_OP_SCLR 4'hC
// widths and reset values
`define BFX_GPR_AW 5
`define BFX_IO_AW 6
`define BFX_FLAGS_RST 8'h00
`define BFX_DATA_RST 8'h00
// execution cycle counts
`define BFX_CLK_ONE 2'h1
`define BFX_CLK_IO 2'h2
`endif

// ### logic/bfx_regfile.v
`timescale 1ns/1ps
module bfx_regfile #(
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [AW-1:0] raddr,
  output reg [7:0] rdata,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata
);
  localparam DEPTH = 1 << AW;
  reg [7:0] mem [0:DEPTH-1];
  // registered read, write port, clears at reset
  integer i;
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= 8'h00;
    end else if (ce) begin
      rdata <= mem[raddr];
      if (we)
        mem[waddr] <= wdata;
    end
  end
endmodule

// ### logic/bfx_exec.v
`timescale 1ns/1ps
`include "bfx_map.vh"
module bfx_exec (
  input wire REF_CLK,
  input wire RST,
  input wire CE,
  input wire OP_VALID,
  input wire [3:0] OP_CODE,
  input wire [4:0] OP_REG,
  input wire [5:0] OP_IO_ADDR,
  input wire [2:0] OP_BIT,
  output wire OP_READY,
  output reg OP_DONE,
  output reg [7:0] STATUS_FLAGS,
  output reg [7:0] RESULT_DATA,
  output reg IO_WE,
  output reg [5:0] IO_ADDR,
  output reg [7:0] IO_WDATA,
  input wire [7:0] IO_RDATA
);
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_IOWR = 2'h2;

  // state and latched operands
  reg [1:0] state_q, state_d;
  reg [3:0] op_q;
  reg [4:0] reg_q;
  reg [2:0] bit_q;

  // next values from the decode
  reg [7:0] flags_d;
  reg [7:0] res_d;
  reg gpr_we;
  reg io_we_d;
  reg [7:0] io_data_d;
  reg done_d;
  wire [7:0] gpr_rdata;
  wire [7:0] bit_mask;
  wire [7:0] io_io;
  wire take;

  // rotate results and io read-modify-write value
  reg [7:0] rot_res;
  reg rot_c;
  reg rot_n;
  reg rot_v;
  reg rot_z;
  reg rot_s;
  reg [7:0] io_mod;

  // the op is taken only while idle; register read is one cycle
  assign OP_READY = (state_q == ST_IDLE);
  assign take = OP_VALID && OP_READY;

  // one-hot mask of the selected bit, built per bit
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_mask
      assign bit_mask[g] = (bit_q == g) ? 1'b1 : 1'b0;
    end
  endgenerate
  assign io_io = IO_RDATA;

  // rotate through carry, both directions
  always @* begin
    if (op_q == `BFX_OP_ROTR) begin
      rot_res = {STATUS_FLAGS[`BFX_FLAG_C], gpr_rdata[7:1]};
      rot_c = gpr_rdata[0];
    end else begin
      rot_res = {gpr_rdata[6:0], STATUS_FLAGS[`BFX_FLAG_C]};
      rot_c = gpr_rdata[7];
    end
    // negative is the new top bit, overflow is N xor C
    rot_n = rot_res[7];
    rot_v = rot_n ^ rot_c;
    rot_z = (rot_res == 8'h00);
    rot_s = rot_n ^ rot_v;
  end

  // io bit forced high or low, other bits kept
  always @* begin
    if (op_q == `BFX_OP_IOSET)
      io_mod = io_io | bit_mask;
    else
      io_mod = io_io & ~bit_mask;
  end

  bfx_regfile #(.AW(`BFX_GPR_AW)) u_gpr (
    .clk(REF_CLK),
    .rst(RST),
    .ce(CE),
    .raddr(take ? OP_REG : reg_q),
    .rdata(gpr_rdata),
    .we(gpr_we),
    .waddr(reg_q),
    .wdata(res_d)
  );

  // operation and flag update
  always @* begin
    state_d = state_q;
    flags_d = STATUS_FLAGS;
    res_d = gpr_rdata;
    gpr_we = 1'b0;
    io_we_d = 1'b0;
    io_data_d = IO_WDATA;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take)
          state_d = ST_EXEC;
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
        done_d = 1'b1;
        case (op_q)
          `BFX_OP_ROTL, `BFX_OP_ROTR: begin
            res_d = rot_res;
            flags_d[`BFX_FLAG_C] = rot_c;
            flags_d[`BFX_FLAG_N] = rot_n;
            flags_d[`BFX_FLAG_Z] = rot_z;
            flags_d[`BFX_FLAG_V] = rot_v;
            flags_d[`BFX_FLAG_S] = rot_s;
            gpr_we = 1'b1;
          end
          `BFX_OP_BSTORE:
            flags_d[`BFX_FLAG_T] = gpr_rdata[bit_q];
          `BFX_OP_BLOAD: begin
            res_d[bit_q] = STATUS_FLAGS[`BFX_FLAG_T];
            gpr_we = 1'b1;
          end
          `BFX_OP_IOSET: begin
            io_data_d = io_mod;
            io_we_d = 1'b1;
            done_d = 1'b0;
            state_d = ST_IOWR;
          end
          `BFX_OP_IOCLR: begin
            io_data_d = io_mod;
            io_we_d = 1'b1;
            done_d = 1'b0;
            state_d = ST_IOWR;
          end
          // single flag writes touch one bit only
          `BFX_OP_VSET: flags_d[`BFX_FLAG_V] = 1'b1;
          `BFX_OP_VCLR: flags_d[`BFX_FLAG_V] = 1'b0;
          `BFX_OP_HSET: flags_d[`BFX_FLAG_H] = 1'b1;
          `BFX_OP_HCLR: flags_d[`BFX_FLAG_H] = 1'b0;
          `BFX_OP_SSET: flags_d[`BFX_FLAG_S] = 1'b1;
          `BFX_OP_SCLR: flags_d[`BFX_FLAG_S] = 1'b0;
          default: res_d = gpr_rdata;
        endcase
      end
      ST_IOWR: begin
        state_d = ST_IDLE; // second clock of io bit ops
        done_d = 1'b1;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // state, flags and completion pulse
  always @(posedge REF_CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      STATUS_FLAGS <= `BFX_FLAGS_RST;
      OP_DONE <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      STATUS_FLAGS <= flags_d;
      OP_DONE <= done_d;
    end
  end

  // operands latched as the request is taken
  always @(posedge REF_CLK) begin
    if (RST) begin
      op_q <= `BFX_OP_NOP;
      reg_q <= 5'h00;
      bit_q <= 3'h0;
      IO_ADDR <= 6'h00;
    end else if (CE && take) begin
      op_q <= OP_CODE;
      reg_q <= OP_REG;
      bit_q <= OP_BIT;
      IO_ADDR <= OP_IO_ADDR;
    end
  end

  // io write strobe and data
  always @(posedge REF_CLK) begin
    if (RST) begin
      IO_WE <= 1'b0;
      IO_WDATA <= `BFX_DATA_RST;
    end else if (CE) begin
      IO_WE <= io_we_d;
      IO_WDATA <= io_data_d;
    end
  end

  // last value written to the register file
  always @(posedge REF_CLK) begin
    if (RST)
      RESULT_DATA <= `BFX_DATA_RST;
    else if (CE && gpr_we)
      RESULT_DATA <= res_d;
  end
endmodule

// ### verif/bfx_exec_assertions.sv
`timescale 1ns/1ps
`include "bfx_map.vh"
module bfx_exec_assertions (
  input wire REF_CLK,
  input wire RST,
  input wire CE,
  input wire OP_VALID,
  input wire [3:0] OP_CODE,
  input wire [2:0] OP_BIT,
  input wire OP_READY,
  input wire OP_DONE,
  input wire [7:0] STATUS_FLAGS,
  input wire [7:0] RESULT_DATA,
  input wire IO_WE,
  input wire [7:0] IO_WDATA,
  input wire [7:0] IO_RDATA
);
  // request taken on this edge, io kind
  wire tk = CE && OP_VALID && OP_READY;
  wire io = OP_CODE == `BFX_OP_IOSET || OP_CODE == `BFX_OP_IOCLR;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // io write pulse, then completion
  sequence io_wr_done;
    ##2 IO_WE ##1 OP_DONE;
  endsequence
  chk_io_order: assert property (tk && io |-> io_wr_done)
    else $error("io order");
  chk_io_set_bit: assert property (
    tk && OP_CODE == `BFX_OP_IOSET |-> ##2
    IO_WDATA == ($past(IO_RDATA) | (8'h01 << $past(OP_BIT, 2))))
    else $error("io set data");
  chk_io_clr_bit: assert property (
    tk && OP_CODE == `BFX_OP_IOCLR |-> ##2
    IO_WDATA == ($past(IO_RDATA) & ~(8'h01 << $past(OP_BIT, 2))))
    else $error("io clear data");
  chk_io_busy: assert property (
    tk && io |=> !OP_READY ##1 !OP_READY) else $error("io busy");
  chk_ce_freeze: assert property (
    !CE |=> $stable(STATUS_FLAGS) && $stable(RESULT_DATA) &&
    $stable(OP_DONE) && $stable(IO_WE)) else $error("enable freeze");
  chk_v_set: assert property (
    tk && OP_CODE == `BFX_OP_VSET |-> ##2 OP_DONE &&
    STATUS_FLAGS == ($past(STATUS_FLAGS) | 8'h08)) else $error("v set");
  chk_h_clear: assert property (
    tk && OP_CODE == `BFX_OP_HCLR |-> ##2 OP_DONE &&
    STATUS_FLAGS == ($past(STATUS_FLAGS) & 8'hDF)) else $error("h clear");
  chk_s_set: assert property (
    tk && OP_CODE == `BFX_OP_SSET |-> ##2 OP_DONE &&
    STATUS_FLAGS == ($past(STATUS_FLAGS) | 8'h10)) else $error("s set");
  chk_rot_flags: assert property (
    tk && (OP_CODE == `BFX_OP_ROTL || OP_CODE == `BFX_OP_ROTR) |-> ##2
    OP_DONE && STATUS_FLAGS[1] == (RESULT_DATA == 8'h00) &&
    STATUS_FLAGS[2] == RESULT_DATA[7] &&
    ((STATUS_FLAGS ^ $past(STATUS_FLAGS)) & 8'hE0) == 8'h00)
    else $error("rotate flags");
  chk_bit_flags: assert property (
    tk && (OP_CODE == `BFX_OP_BSTORE || OP_CODE == `BFX_OP_BLOAD) |-> ##2
    OP_DONE && ((STATUS_FLAGS ^ $past(STATUS_FLAGS)) & 8'hBF) == 8'h00)
    else $error("bit op flags");
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
`include "bfx_map.vh"
module tb;
  reg REF_CLK = 1'b0, RST = 1'b1, OP_VALID = 1'b0, CE = 1'b1;
  reg [3:0] OP_CODE = 4'h0;
  reg [4:0] OP_REG = 5'h00;
  reg [5:0] OP_IO_ADDR = 6'h00, wa_q = 6'h00;
  reg [2:0] OP_BIT = 3'h0;
  reg [7:0] IO_RDATA = 8'hA5, wr_q = 8'h00;
  wire OP_READY, OP_DONE, IO_WE;
  wire [7:0] STATUS_FLAGS, RESULT_DATA, IO_WDATA;
  wire [5:0] IO_ADDR;
  int fail_count = 0, checked = 0, cyc = 0, n;
  bfx_exec uut (.REF_CLK, .RST, .CE, .OP_VALID, .OP_CODE, .OP_REG,
    .OP_IO_ADDR, .OP_BIT, .OP_READY, .OP_DONE, .STATUS_FLAGS, .RESULT_DATA,
    .IO_WE, .IO_ADDR, .IO_WDATA, .IO_RDATA);
  initial forever #12.5 REF_CLK = ~REF_CLK;
  // io write capture and hang guard
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (IO_WE === 1'b1) begin
      wr_q <= IO_WDATA;
      wa_q <= IO_ADDR;
    end
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop;
    end
  end
  task automatic cmp(input string s, input [7:0] e, input [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // one request, n = edges from take to done
  task automatic run(input [3:0] c, input [5:0] a, input [2:0] b);
    @(posedge REF_CLK);
    OP_CODE <= c;
    OP_IO_ADDR <= a;
    OP_REG <= {2'b00, b};
    OP_BIT <= b;
    OP_VALID <= 1'b1;
    @(posedge REF_CLK);
    OP_VALID <= 1'b0;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
      #1;
    end while (OP_DONE !== 1'b1 && n < 8);
  endtask
  task automatic t_flags;
    reg [7:0] f, m;
    f = 8'h00;
    for (int i = 0; i < 6; i++) begin
      m = (i % 3 == 0) ? 8'h08 : (i % 3 == 1) ? 8'h20 : 8'h10;
      f = (i < 3) ? (f | m) : (f & ~m);
      run(i < 3 ? 4'(7 + 2 * i) : 4'(2 + 2 * i), 6'h00, 3'h0);
      cmp("edges", {6'h00, `BFX_CLK_ONE}, n[7:0]);
      cmp("flags", f, STATUS_FLAGS);
    end
    $display("flag test end");
  endtask
  task automatic t_rot;
    run(`BFX_OP_HSET, 6'h00, 3'h0);
    for (int i = 1; i < 5; i++) begin
      run(4'(i), 6'h00, 3'h3);
      cmp("edges", {6'h00, `BFX_CLK_ONE}, n[7:0]);
      cmp("flags", 8'h22, STATUS_FLAGS);
      cmp("result", 8'h00, RESULT_DATA);
    end
    $display("rotate test end");
  endtask
  task automatic t_io;
    reg [7:0] m;
    for (int i = 0; i < 16; i++) begin
      m = 8'h01 << i[2:0];
      run(i < 8 ? `BFX_OP_IOSET : `BFX_OP_IOCLR, 6'(i + 32), 3'(i));
      cmp("edges", {6'h00, `BFX_CLK_IO}, n[7:0]);
      cmp("io data", i < 8 ? 8'hA5 | m : 8'hA5 & ~m, wr_q);
      cmp("io addr", 8'(i + 32), {2'b00, wa_q});
      cmp("flags", 8'h22, STATUS_FLAGS);
    end
    $display("io test end");
  endtask
  // request held while the clock enable is low
  task automatic t_ce;
    @(posedge REF_CLK);
    CE <= 1'b0;
    OP_CODE <= `BFX_OP_VSET;
    OP_VALID <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    #1;
    cmp("frozen flags", 8'h22, STATUS_FLAGS);
    cmp("frozen done", 8'h00, {7'h00, OP_DONE});
    @(posedge REF_CLK);
    CE <= 1'b1;
    OP_VALID <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    #1;
    cmp("flags after freeze", 8'h22, STATUS_FLAGS);
    $display("clock enable test end");
  endtask
  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge REF_CLK);
    RST <= 1'b0;
    #1;
    cmp("reset flags", 8'h00, STATUS_FLAGS);
    t_flags;
    t_rot;
    t_io;
    t_ce;
    report_and_stop;
  end
endmodule
bind bfx_exec bfx_exec_assertions chk (.REF_CLK, .RST, .CE, .OP_VALID,
  .OP_CODE, .OP_BIT, .OP_READY, .OP_DONE, .STATUS_FLAGS, .RESULT_DATA,
  .IO_WE, .IO_WDATA, .IO_RDATA);
